// ===== rtl/swcfg_map.svh
// register map, command codes, field positions and timing constants of the switch input configuration block
`ifndef SWCFG_MAP_SVH
`define SWCFG_MAP_SVH
`define SWCFG_FRAME_BITS 24
`define SWCFG_CMD_HI 23
`define SWCFG_CMD_LO 16
`define SWCFG_CMD_WAKE_PROG 8'h02
`define SWCFG_CMD_WAKE_GND 8'h03
`define SWCFG_CMD_LEVEL_PROG 8'h04
`define SWCFG_CMD_LEVEL_GND 8'h05
`define SWCFG_CMD_ANALOG 8'h06
`define SWCFG_CMD_TIMER_PROG 8'h07
`define SWCFG_CMD_TIMER_GND 8'h08
`define SWCFG_CMD_HIZ_PROG 8'h09
`define SWCFG_CMD_HIZ_GND 8'h0a
`define SWCFG_CMD_RESET 8'h7f
`define SWCFG_CHAN_HI 4
`define SWCFG_CUR_LO_BIT 5
`define SWCFG_CUR_HI_BIT 6
`define SWCFG_CHAN_NONE 5'h00
`define SWCFG_CHAN_GND0 5'h01
`define SWCFG_CHAN_PROG0 5'h0f
`define SWCFG_CHAN_LAST 5'h16
`define SWCFG_RST_PROG 8'hff
`define SWCFG_RST_GND 14'h3fff
`define SWCFG_RST_ANALOG 7'h00
`define SWCFG_WET_TIME_US 20000
`define SWCFG_CLK_MHZ 50
`endif

// ===== rtl/swcfg_pkg.sv
// types shared by the switch input configuration block
package swcfg_pkg;
   typedef enum logic [1:0] {SWCFG_CUR_HIZ, SWCFG_CUR_LOW, SWCFG_CUR_HIGH} swcfg_cur_t;
endpackage : swcfg_pkg

// ===== rtl/swcfg_wet_timer.sv
// one input's wetting timer: high current for a fixed time after a threshold crossing
`timescale 1ns/10ps
`default_nettype none
module swcfg_wet_timer #(
   parameter int CYCLES = 1000000
)
(
   // clock and reset
   input wire logic sysClk,
   input wire logic rstn,
   // control
   input wire logic crossing,
   input wire logic timerEn,
   // status
   output logic expired
);
   typedef struct packed
   {
      logic [31:0] count;
      logic done;
   } swcfg_wt_state_t;
   swcfg_wt_state_t st_reg;
   swcfg_wt_state_t st_next;
   initial
   begin
      if (CYCLES < 1) $error("wetting time must be at least one cycle");
   end
   always_comb
   begin
      st_next = st_reg;
      if (crossing)
      begin
         st_next.count = 32'h0;
         st_next.done = 1'b0;
      end
      else if (!st_reg.done)
      begin
         if (st_reg.count == 32'(CYCLES - 1))
            st_next.done = 1'b1;
         else
            st_next.count = st_reg.count + 32'h1;
      end
   end
   always_ff @(posedge sysClk)
   begin
      if (!rstn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
   // a disabled timer never drops the current
   assign expired = st_reg.done & timerEn;
endmodule : swcfg_wet_timer
`default_nettype wire

// ===== rtl/switch_input_config_regs.sv
// serial configuration registers and per-input current control of the switch detection device
`timescale 1ns/10ps
`default_nettype none
`include "swcfg_map.svh"
module switch_input_config_regs #(
   parameter int N_PROG = 8,
   parameter int N_GND = 14,
   parameter int WET_CYCLES = (`SWCFG_WET_TIME_US * `SWCFG_CLK_MHZ)
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // serial port from the host
   input wire logic serClk,
   input wire logic chipSelN,
   input wire logic serDataIn,
   // device state
   input wire logic normalMode,
   input wire logic logicSupplyOk,
   input wire logic sleepMode,
   // comparator outputs, one = closed
   input wire logic [N_PROG-1:0] progInputClosed,
   input wire logic [N_GND-1:0] groundOnlyInputClosed,
   // per-input current control
   output logic [N_PROG-1:0] progPullUpHigh,
   output logic [N_PROG-1:0] progPullUpLow,
   output logic [N_PROG-1:0] progHighImpedance,
   output logic [N_GND-1:0] groundOnlyPullUpHigh,
   output logic [N_GND-1:0] groundOnlyPullUpLow,
   output logic [N_GND-1:0] groundOnlyHighImpedance,
   // analog mux for the analog_out_pin buffer
   output logic [4:0] analogOutSelect,
   // status reported to the host, analog channel masked
   output logic [N_PROG-1:0] progStatus,
   output logic [N_GND-1:0] groundOnlyStatus,
   // events
   output logic alertN,
   output logic wakeReq
);
   localparam int N_ALL = N_PROG + N_GND;
   initial
   begin
      if (N_PROG != 8 || N_GND != 14) $error("command layout serves 8 and 14 inputs only");
      if (WET_CYCLES < 1) $error("wetting time too short");
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed
   {
      logic [1:0] clkSync;
      logic [1:0] csSync;
      logic [1:0] sdSync;
      logic clkPrev;
      logic csPrev;
      logic [23:0] shift;
      logic [5:0] bitCnt;
      logic [N_PROG-1:0] wakeProg;
      logic [N_GND-1:0] wakeGnd;
      logic [N_PROG-1:0] levelProg;
      logic [N_GND-1:0] levelGnd;
      logic [N_PROG-1:0] timerProg;
      logic [N_GND-1:0] timerGnd;
      logic [N_PROG-1:0] hizProg;
      logic [N_GND-1:0] hizGnd;
      logic [6:0] analogSel;
      logic [N_ALL-1:0] closedPrev;
      logic [N_ALL-1:0] crossPulse;
      logic alertN;
      logic wake;
      logic [N_ALL-1:0] status;
   } swcfg_state_t;
   swcfg_state_t st_reg;
   swcfg_state_t st_next;

   logic [N_ALL-1:0] closedNow;
   logic [N_ALL-1:0] wetExpired;
   logic [N_ALL-1:0] analogHit;
   logic [N_ALL-1:0] pullHigh;
   logic [N_ALL-1:0] pullLow;
   logic [N_ALL-1:0] hiz;
   logic [N_ALL-1:0] timerEnAll;
   logic [N_ALL-1:0] wakeAll;
   logic [N_ALL-1:0] levelAll;
   logic [N_ALL-1:0] changed;
   logic [23:0] frame;
   logic [7:0] cmd;
   logic frameEnd;
   logic acceptCfg;
   logic [4:0] chan;
   swcfg_pkg::swcfg_cur_t anaCur;

   // ground-only inputs occupy the low bits, matching the channel numbering
   assign closedNow = {progInputClosed, groundOnlyInputClosed};
   assign timerEnAll = {st_reg.timerProg, st_reg.timerGnd};
   assign wakeAll = {st_reg.wakeProg, st_reg.wakeGnd};
   assign levelAll = {st_reg.levelProg, st_reg.levelGnd};
   assign frame = st_reg.shift;
   assign cmd = frame[`SWCFG_CMD_HI:`SWCFG_CMD_LO];
   assign chan = st_reg.analogSel[`SWCFG_CHAN_HI:0];

   // ----------------------------------------
   // wetting timers
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < N_ALL; gi++)
      begin : g_wet
         swcfg_wet_timer #(
            .CYCLES(WET_CYCLES)
         ) u_timer (
            .sysClk(sys_clk),
            .rstn(rstn),
            .crossing(st_reg.crossPulse[gi]),
            .timerEn(timerEnAll[gi]),
            .expired(wetExpired[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // current selection
   // ----------------------------------------
   always_comb
   begin
      case ({st_reg.analogSel[`SWCFG_CUR_HI_BIT], st_reg.analogSel[`SWCFG_CUR_LO_BIT]})
         2'h1: anaCur = swcfg_pkg::SWCFG_CUR_LOW;
         2'h2: anaCur = swcfg_pkg::SWCFG_CUR_HIGH;
         default: anaCur = swcfg_pkg::SWCFG_CUR_HIZ;
      endcase
   end

   always_comb
   begin
      analogHit = '0;
      for (int i = 0; i < N_ALL; i++)
      begin
         // only codes 1..22 hit an input; code 0 and higher codes select nothing
         if (chan != `SWCFG_CHAN_NONE && chan <= `SWCFG_CHAN_LAST && 32'(chan) == i + 1)
            analogHit[i] = 1'b1;
      end
   end

   always_comb
   begin
      hiz = {st_reg.hizProg, st_reg.hizGnd};
      pullHigh = '0;
      pullLow = '0;
      for (int i = 0; i < N_ALL; i++)
      begin
         if (analogHit[i])
         begin
            // analog currents are pull-ups; direction of the source is fixed up by the pad
            hiz[i] = (anaCur == swcfg_pkg::SWCFG_CUR_HIZ);
            pullHigh[i] = (anaCur == swcfg_pkg::SWCFG_CUR_HIGH);
            pullLow[i] = (anaCur == swcfg_pkg::SWCFG_CUR_LOW);
         end
         else if (!hiz[i])
         begin
            if (levelAll[i] && !wetExpired[i])
               pullHigh[i] = 1'b1;
            else
               pullLow[i] = 1'b1;
         end
         // hiz[i] set: no current at all
      end
   end

   // ----------------------------------------
   // serial receive and register update
   // ----------------------------------------
   assign frameEnd = st_reg.csSync[1] & ~st_reg.csPrev;
   assign acceptCfg = frameEnd && st_reg.bitCnt == 6'(`SWCFG_FRAME_BITS)
      && normalMode && logicSupplyOk;
   assign changed = closedNow ^ st_reg.closedPrev;

   always_comb
   begin
      st_next = st_reg;
      st_next.clkSync = {st_reg.clkSync[0], serClk};
      st_next.csSync = {st_reg.csSync[0], chipSelN};
      st_next.sdSync = {st_reg.sdSync[0], serDataIn};
      st_next.clkPrev = st_reg.clkSync[1];
      st_next.csPrev = st_reg.csSync[1];
      if (st_reg.csSync[1])
         st_next.bitCnt = '0;
      else if (st_reg.clkSync[1] && !st_reg.clkPrev)
      begin
         st_next.shift = {st_reg.shift[22:0], st_reg.sdSync[1]};
         if (st_reg.bitCnt != 6'h3f)
            st_next.bitCnt = st_reg.bitCnt + 6'h01;
      end
      if (acceptCfg)
      begin
         case (cmd)
            `SWCFG_CMD_WAKE_PROG: st_next.wakeProg = frame[N_PROG-1:0];
            `SWCFG_CMD_WAKE_GND: st_next.wakeGnd = frame[N_GND-1:0];
            `SWCFG_CMD_LEVEL_PROG: st_next.levelProg = frame[N_PROG-1:0];
            `SWCFG_CMD_LEVEL_GND: st_next.levelGnd = frame[N_GND-1:0];
            `SWCFG_CMD_TIMER_PROG: st_next.timerProg = frame[N_PROG-1:0];
            `SWCFG_CMD_TIMER_GND: st_next.timerGnd = frame[N_GND-1:0];
            `SWCFG_CMD_HIZ_PROG: st_next.hizProg = frame[N_PROG-1:0];
            `SWCFG_CMD_HIZ_GND: st_next.hizGnd = frame[N_GND-1:0];
            `SWCFG_CMD_ANALOG: st_next.analogSel = frame[6:0];
            `SWCFG_CMD_RESET:
            begin
               st_next.wakeProg = `SWCFG_RST_PROG;
               st_next.wakeGnd = `SWCFG_RST_GND;
               st_next.levelProg = `SWCFG_RST_PROG;
               st_next.levelGnd = `SWCFG_RST_GND;
               st_next.timerProg = `SWCFG_RST_PROG;
               st_next.timerGnd = `SWCFG_RST_GND;
               st_next.hizProg = `SWCFG_RST_PROG;
               st_next.hizGnd = `SWCFG_RST_GND;
               st_next.analogSel = `SWCFG_RST_ANALOG;
            end
            default: ;
         endcase
      end

      // ----------------------------------------
      // change detection, alert and wake
      // ----------------------------------------
      st_next.closedPrev = closedNow;
      // comparators stay live in high impedance, so crossings and status keep flowing
      st_next.crossPulse = changed;
      st_next.status = closedNow & ~analogHit;
      st_next.wake = 1'b0;
      if (|(changed & wakeAll))
      begin
         if (sleepMode)
            st_next.wake = 1'b1;
         else if (normalMode)
            st_next.alertN = 1'b0;
      end
      else if (frameEnd)
         st_next.alertN = 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
         st_reg.clkSync <= 2'h0;
         st_reg.csSync <= 2'h3;
         st_reg.csPrev <= 1'b1;
         st_reg.wakeProg <= `SWCFG_RST_PROG;
         st_reg.wakeGnd <= `SWCFG_RST_GND;
         st_reg.levelProg <= `SWCFG_RST_PROG;
         st_reg.levelGnd <= `SWCFG_RST_GND;
         st_reg.timerProg <= `SWCFG_RST_PROG;
         st_reg.timerGnd <= `SWCFG_RST_GND;
         st_reg.hizProg <= `SWCFG_RST_PROG;
         st_reg.hizGnd <= `SWCFG_RST_GND;
         st_reg.analogSel <= `SWCFG_RST_ANALOG;
         st_reg.alertN <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_comb
   begin
      progPullUpHigh = pullHigh[N_ALL-1:N_GND];
      progPullUpLow = pullLow[N_ALL-1:N_GND];
      progHighImpedance = hiz[N_ALL-1:N_GND];
      groundOnlyPullUpHigh = pullHigh[N_GND-1:0];
      groundOnlyPullUpLow = pullLow[N_GND-1:0];
      groundOnlyHighImpedance = hiz[N_GND-1:0];
      analogOutSelect = (chan <= `SWCFG_CHAN_LAST) ? chan : `SWCFG_CHAN_NONE;
      progStatus = st_reg.status[N_ALL-1:N_GND];
      groundOnlyStatus = st_reg.status[N_GND-1:0];
      alertN = st_reg.alertN;
      wakeReq = st_reg.wake;
   end
endmodule : switch_input_config_regs
`default_nettype wire

// ===== tb/swcfg_regs_monitor.sv
// concurrent checks on the ports of the switch input configuration block
`timescale 1ns/10ps
`default_nettype none
module swcfg_regs_monitor #(
   parameter int N_PROG = 8,
   parameter int N_GND = 14
)
(
   // clock, reset and device state
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic normalMode,
   input wire logic logicSupplyOk,
   input wire logic sleepMode,
   // comparator results and status
   input wire logic [N_PROG-1:0] progInputClosed,
   input wire logic [N_GND-1:0] groundOnlyInputClosed,
   input wire logic [N_PROG-1:0] progStatus,
   input wire logic [N_GND-1:0] groundOnlyStatus,
   // current control and mux
   input wire logic [N_PROG-1:0] progPullUpHigh,
   input wire logic [N_PROG-1:0] progPullUpLow,
   input wire logic [N_PROG-1:0] progHighImpedance,
   input wire logic [N_GND-1:0] groundOnlyPullUpHigh,
   input wire logic [N_GND-1:0] groundOnlyPullUpLow,
   input wire logic [N_GND-1:0] groundOnlyHighImpedance,
   input wire logic [4:0] analogOutSelect,
   // events
   input wire logic alertN,
   input wire logic wakeReq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // change between the two samples before the event, since alert and wake are registered
   sequence inChange;
      $past(progInputClosed) != $past(progInputClosed, 2) ||
      $past(groundOnlyInputClosed) != $past(groundOnlyInputClosed, 2);
   endsequence
   sequence onePulse;
      wakeReq ##1 !wakeReq;
   endsequence
   reset_defaults_a: assert property ($rose(rstn) |->
      &progHighImpedance && &groundOnlyHighImpedance && alertN && !wakeReq && analogOutSelect == 5'h00)
      else $error("defaults wrong after reset");
   current_onehot_a: assert property ((progPullUpHigh ^ progPullUpLow ^ progHighImpedance) == '1 &&
      ((progPullUpHigh & progPullUpLow) | (progHighImpedance & (progPullUpHigh | progPullUpLow))) == '0)
      else $error("current controls not one of three");
   gnd_current_a: assert property (
      (groundOnlyPullUpHigh ^ groundOnlyPullUpLow ^ groundOnlyHighImpedance) == '1 &&
      ((groundOnlyPullUpHigh & groundOnlyPullUpLow) |
      (groundOnlyHighImpedance & (groundOnlyPullUpHigh | groundOnlyPullUpLow))) == '0)
      else $error("ground current controls not one of three");
   chan_range_a: assert property (analogOutSelect <= 5'h16)
      else $error("mux code out of range");
   analog_mask_a: assert property (analogOutSelect != 5'h00 && $stable(analogOutSelect) &&
      $past(analogOutSelect, 2) == analogOutSelect |-> (analogOutSelect >= 5'h0f) ?
      !progStatus[analogOutSelect - 5'h0f] : !groundOnlyStatus[analogOutSelect - 5'h01])
      else $error("analog input status not zero");
   wake_pulse_a: assert property (wakeReq |-> onePulse)
      else $error("wake request longer than one cycle");
   wake_sleep_a: assert property (wakeReq |-> $past(sleepMode) ##0 inChange)
      else $error("wake request without sleep or change");
   alert_cause_a: assert property ($fell(alertN) |-> $past(normalMode) ##0 inChange)
      else $error("alert without a change in normal mode");
   hold_outside_a: assert property ($changed(analogOutSelect) |->
      $past(normalMode) && $past(logicSupplyOk))
      else $error("register changed outside normal mode");
endmodule : swcfg_regs_monitor
`default_nettype wire

// ===== tb/swcfg_host.sv
// host serial master model: frames of up to 24 bits, serial clock idle low between frames
`timescale 1ns/10ps
`default_nettype none
module swcfg_host
(
   // bench clock
   input wire logic sysClk,
   // serial lines
   output logic serClk,
   output logic chipSelN,
   output logic serDataIn
);
   initial
   begin
      serClk = 1'b0;
      chipSelN = 1'b1;
      serDataIn = 1'b0;
   end
   // four system clocks a phase gives the 160 ns bit period
   task automatic send(input logic [23:0] frame, input int nBits);
      @(posedge sysClk) chipSelN <= 1'b0;
      for (int i = 23; i > 23 - nBits; i--)
      begin
         // data moves with the falling serial clock, four cycles ahead of the rise
         serDataIn <= frame[i];
         repeat (4) @(posedge sysClk);
         serClk <= 1'b1;
         repeat (4) @(posedge sysClk);
         serClk <= 1'b0;
      end
      repeat (4) @(posedge sysClk);
      chipSelN <= 1'b1;
      // no pull on the data line: show the inverse once released
      serDataIn <= ~serDataIn;
      repeat (10) @(posedge sysClk);
   endtask : send
endmodule : swcfg_host
`default_nettype wire

// ===== tb/switch_input_config_regs_tb.sv
// self-checking bench of the switch input configuration block
`timescale 1ns/10ps
`default_nettype none
module switch_input_config_regs_tb;
   // short wetting time keeps the run brief
   localparam int WET = 50;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic normalMode = 1'b1;
   logic logicSupplyOk = 1'b1;
   logic sleepMode = 1'b0;
   logic [7:0] progIn = 8'h00;
   logic [13:0] gndIn = 14'h0000;
   logic serClk, chipSelN, serDataIn, alertN, wakeReq;
   logic [7:0] pHi, pLo, pZ, pSt;
   logic [13:0] gHi, gLo, gZ, gSt;
   logic [4:0] aSel;
   int n_fail = 0;
   int comparisons = 0;
   always #10 sys_clk = ~sys_clk;
   swcfg_host host (.sysClk(sys_clk), .serClk, .chipSelN, .serDataIn);
   switch_input_config_regs #(.WET_CYCLES(WET)) uut (.sys_clk, .rstn, .serClk, .chipSelN, .serDataIn, .normalMode,
      .logicSupplyOk, .sleepMode, .progInputClosed(progIn), .groundOnlyInputClosed(gndIn), .progPullUpHigh(pHi),
      .progPullUpLow(pLo), .progHighImpedance(pZ), .groundOnlyPullUpHigh(gHi), .groundOnlyPullUpLow(gLo),
      .groundOnlyHighImpedance(gZ), .analogOutSelect(aSel), .progStatus(pSt), .groundOnlyStatus(gSt), .alertN, .wakeReq);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic tx(input logic [7:0] cmd, input logic [15:0] dat);
      host.send({cmd, dat}, 24);
      #1;
   endtask : tx
   task automatic flip(input logic [7:0] p);
      @(posedge sys_clk) progIn <= progIn ^ p;
   endtask : flip
   task automatic wrap_up;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_defaults;
      chk({pZ, gZ, aSel, alertN}, {8'hff, 14'h3fff, 5'h00, 1'b1});
   endtask : t_defaults
   task automatic t_current;
      tx(8'h07, 16'h0000);
      tx(8'h09, 16'hff00);
      tx(8'h04, 16'h000f);
      chk({pHi, pLo, pZ}, {8'h0f, 8'hf0, 8'h00});
      flip(8'h01);
      cyc(WET + 20);
      chk(pHi, 8'h0f);
      tx(8'h07, 16'h0001);
      flip(8'h01);
      cyc(10);
      chk({pHi[0], pLo[0]}, 2'b10);
      cyc(WET + 10);
      chk({pHi[0], pLo[0]}, 2'b01);
      tx(8'h0a, 16'h0000);
      tx(8'h08, 16'h0000);
      tx(8'h05, 16'hc001);
      chk({gHi, gZ}, {14'h0001, 14'h0000});
      chk(gLo, 14'h3ffe);
   endtask : t_current
   task automatic t_wake;
      int seen;
      seen = 0;
      tx(8'h02, 16'hff01);
      tx(8'h03, 16'h0000);
      chk(alertN, 1'b1);
      flip(8'h02);
      @(posedge sys_clk) gndIn <= gndIn ^ 14'h0004;
      cyc(4);
      chk(alertN, 1'b1);
      flip(8'h01);
      cyc(4);
      chk(alertN, 1'b0);
      @(posedge sys_clk) sleepMode <= 1'b1;
      flip(8'h02);
      flip(8'h01);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge sys_clk);
         #1 seen += (wakeReq === 1'b1);
      end
      chk(seen, 1);
      @(posedge sys_clk) sleepMode <= 1'b0;
   endtask : t_wake
   task automatic t_analog;
      logic [2:0] want;
      @(posedge sys_clk) progIn <= 8'h03;
      for (int c = 0; c < 4; c++)
      begin
         want = (c == 1) ? 3'b010 : (c == 2) ? 3'b100 : 3'b001;
         tx(8'h06, {9'h000, c[1:0], 5'h0f});
         chk(aSel, 5'h0f);
         chk({pHi[0], pLo[0], pZ[0]}, want);
         chk(pSt[1:0], 2'b10);
      end
      tx(8'h06, 16'h0041);
      chk({aSel, gHi[0]}, {5'h01, 1'b1});
      tx(8'h06, 16'h0016);
      chk(aSel, 5'h16);
      tx(8'h06, 16'h0017);
      chk(aSel, 5'h00);
   endtask : t_analog
   task automatic t_refuse;
      tx(8'h06, 16'h0005);
      host.send(24'h060009, 23);
      #1 chk(aSel, 5'h05);
      @(posedge sys_clk) normalMode <= 1'b0;
      tx(8'h06, 16'h0009);
      chk(aSel, 5'h05);
      @(posedge sys_clk) normalMode <= 1'b1;
      logicSupplyOk <= 1'b0;
      tx(8'h06, 16'h0009);
      chk(aSel, 5'h05);
      @(posedge sys_clk) logicSupplyOk <= 1'b1;
      tx(8'h7f, 16'h0000);
      t_defaults;
      flip(8'h04);
      cyc(3);
      chk({pSt, gSt}, {8'h07, 14'h0004});
   endtask : t_refuse
   initial
   begin
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      cyc(3);
      t_defaults;
      t_current;
      t_wake;
      t_analog;
      t_refuse;
      wrap_up;
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      wrap_up;
   end
endmodule : switch_input_config_regs_tb
bind switch_input_config_regs swcfg_regs_monitor #(.N_PROG(N_PROG), .N_GND(N_GND)) mon (.sys_clk, .rstn, .normalMode,
   .logicSupplyOk, .sleepMode, .progInputClosed, .groundOnlyInputClosed, .progStatus, .groundOnlyStatus,
   .progPullUpHigh, .progPullUpLow, .progHighImpedance, .groundOnlyPullUpHigh, .groundOnlyPullUpLow,
   .groundOnlyHighImpedance, .analogOutSelect, .alertN, .wakeReq);
`default_nettype wire
